// ===== hw/flrlw_consts.svh
`ifndef FLRLW_CONSTS_SVH
`define FLRLW_CONSTS_SVH

// ****************************************************************
// read command opcodes
// ****************************************************************
`define FLRLW_CMD_FAST_READ 8'h0b
`define FLRLW_CMD_FAST_READ_DR 8'h0d
`define FLRLW_CMD_DUAL_OUT 8'h3b
`define FLRLW_CMD_QUAD_OUT 8'h6b
`define FLRLW_CMD_DUAL_IO 8'hbb
`define FLRLW_CMD_DUAL_IO_DR 8'hbd
`define FLRLW_CMD_QUAD_IO 8'heb
`define FLRLW_CMD_QUAD_IO_DR 8'hed

// ****************************************************************
// default latencies in dummy clocks
// ****************************************************************
`define FLRLW_LAT_FAST_SERIAL 4'h8
`define FLRLW_LAT_FAST_FOUR_WIRE 4'h6
`define FLRLW_LAT_OUTPUT_READ 4'h8
`define FLRLW_LAT_DUAL_IO 4'h4
`define FLRLW_LAT_QUAD_IO 4'h6
`define FLRLW_LAT_USE_DEFAULT 4'h0

// ****************************************************************
// wrap boundary sizes in bytes, indexed by burst length field
// ****************************************************************
`define FLRLW_WRAP_8 7'h08
`define FLRLW_WRAP_16 7'h10
`define FLRLW_WRAP_32 7'h20
`define FLRLW_WRAP_64 7'h40

`define FLRLW_ADDR_W 24

`endif

// ===== hw/flrlw_pkg.sv
package flrlw_pkg;

	// sequencer phases of one read frame
	typedef enum logic [1:0] {
		FLRLW_IDLE,
		FLRLW_ADDR,
		FLRLW_DUMMY,
		FLRLW_DATA
	} flrlw_state_e;

	typedef logic [1:0] flrlw_burst_t;
	typedef logic [3:0] flrlw_lat_t;

endpackage

// ===== hw/flrlw_read_latency.sv
// What this block does
// - wrap off: linear read, burst field ignored
// - wrap on: address wraps in aligned boundary
// - burst field: 8, 16, 32, 64 bytes
// - zero uses default, else exact dummy count
// - serial fast read, id, info: 8
// - four-wire fast read: 6 dummies
// - dual/quad output reads: 8 dummies
// - dual io reads: 4 dummies
// - quad io reads: 6 dummies, both modes
// - dual io (both rates) and dual/quad output reads only in serial mode
`timescale 1ns/10ps
`include "flrlw_consts.svh"

module flrlw_read_latency #(
	parameter int ADDR_W = `FLRLW_ADDR_W,
	parameter logic [7:0] UID_READ_CMD = 8'hf1,
	parameter logic [7:0] INFO_READ_CMD = 8'hf2
) (
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire logic SCLK,
	input wire logic CS_N,
	input wire logic CMD_VALID,
	input wire logic [7:0] CMD_CODE,
	input wire logic FOUR_WIRE_MODE,
	input wire logic ADDR_DONE,
	input wire logic [ADDR_W-1:0] START_ADDR,
	input wire logic BYTE_DONE,
	input wire logic WRAP_ENABLE_BIT,
	input wire logic BURST_SIZE_BIT_HIGH,
	input wire logic BURST_SIZE_BIT_LOW,
	input wire flrlw_pkg::flrlw_lat_t DUMMY_CYCLES,
	output logic DATA_ENABLE,
	output logic IN_DUMMY,
	output logic CMD_REJECT,
	output flrlw_pkg::flrlw_lat_t LATENCY,
	output logic [ADDR_W-1:0] READ_ADDR
);
	import flrlw_pkg::*;

	// ****************************************************************
	// pin synchronisers
	// ****************************************************************
	logic sclk_s1_q;
	logic sclk_s2_q;
	logic sclk_s3_q;
	logic csn_s1_q;
	logic csn_s2_q;
	logic sclk_rise;
	logic sclk_fall;

	// two flops before any use; third flop only for edge finding
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			sclk_s1_q <= 1'b0;
			sclk_s2_q <= 1'b0;
			sclk_s3_q <= 1'b0;
			csn_s1_q <= 1'b1;
			csn_s2_q <= 1'b1;
		end else begin
			sclk_s1_q <= SCLK;
			sclk_s2_q <= sclk_s1_q;
			sclk_s3_q <= sclk_s2_q;
			csn_s1_q <= CS_N;
			csn_s2_q <= csn_s1_q;
		end
	end

	assign sclk_rise = sclk_s2_q & ~sclk_s3_q;
	assign sclk_fall = ~sclk_s2_q & sclk_s3_q;

	// ****************************************************************
	// command decode and latency choice
	// ****************************************************************
	flrlw_lat_t def_lat;
	logic cmd_known;
	logic cmd_bad_mode;

	// default latency per opcode and command mode
	always_comb begin
		def_lat = `FLRLW_LAT_FAST_SERIAL;
		cmd_known = 1'b1;
		cmd_bad_mode = 1'b0;
		if (CMD_CODE == `FLRLW_CMD_FAST_READ || CMD_CODE == `FLRLW_CMD_FAST_READ_DR) begin
			def_lat = FOUR_WIRE_MODE ? `FLRLW_LAT_FAST_FOUR_WIRE : `FLRLW_LAT_FAST_SERIAL;
		end else if (CMD_CODE == UID_READ_CMD || CMD_CODE == INFO_READ_CMD) begin
			def_lat = FOUR_WIRE_MODE ? `FLRLW_LAT_FAST_FOUR_WIRE : `FLRLW_LAT_FAST_SERIAL;
		end else if (CMD_CODE == `FLRLW_CMD_DUAL_OUT || CMD_CODE == `FLRLW_CMD_QUAD_OUT) begin
			def_lat = `FLRLW_LAT_OUTPUT_READ;
			cmd_bad_mode = FOUR_WIRE_MODE;
		end else if (CMD_CODE == `FLRLW_CMD_DUAL_IO) begin
			def_lat = `FLRLW_LAT_DUAL_IO;
			cmd_bad_mode = FOUR_WIRE_MODE;
		end else if (CMD_CODE == `FLRLW_CMD_DUAL_IO_DR) begin
			def_lat = `FLRLW_LAT_DUAL_IO;
			cmd_bad_mode = FOUR_WIRE_MODE;
		end else if (CMD_CODE == `FLRLW_CMD_QUAD_IO || CMD_CODE == `FLRLW_CMD_QUAD_IO_DR) begin
			def_lat = `FLRLW_LAT_QUAD_IO;
		end else begin
			cmd_known = 1'b0;
		end
	end

	// ****************************************************************
	// read sequencer
	// ****************************************************************
	flrlw_state_e state_q;
	flrlw_state_e state_d;
	flrlw_lat_t lat_q;
	flrlw_lat_t cnt_q;
	logic last_dummy_q;
	logic accept;

	assign accept = CMD_VALID & cmd_known & ~cmd_bad_mode;

	// next phase; chip select high ends any frame at once
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			FLRLW_IDLE: begin
				if (accept && !csn_s2_q) begin
					state_d = FLRLW_ADDR;
				end
			end
			FLRLW_ADDR: begin
				if (ADDR_DONE) begin
					state_d = FLRLW_DUMMY;
				end
			end
			FLRLW_DUMMY: begin
				// data on edge after last dummy
				if (last_dummy_q && sclk_fall) begin
					state_d = FLRLW_DATA;
				end
			end
			FLRLW_DATA: begin
				state_d = FLRLW_DATA;
			end
		endcase
		if (csn_s2_q) begin
			state_d = FLRLW_IDLE;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			state_q <= FLRLW_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// latency is frozen at command time so a parameter change mid-frame is harmless
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			lat_q <= `FLRLW_LAT_FAST_SERIAL;
		end else if (state_q == FLRLW_IDLE && accept) begin
			lat_q <= (DUMMY_CYCLES == `FLRLW_LAT_USE_DEFAULT) ? def_lat : DUMMY_CYCLES;
		end
	end

	// dummy clocks counted on rising serial clock edges after address phase
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			cnt_q <= 4'h0;
			last_dummy_q <= 1'b0;
		end else if (state_q != FLRLW_DUMMY) begin
			cnt_q <= 4'h0;
			last_dummy_q <= 1'b0;
		end else if (sclk_rise && !last_dummy_q) begin
			cnt_q <= cnt_q + 4'h1;
			last_dummy_q <= (cnt_q + 4'h1) == lat_q;
		end
	end

	// ****************************************************************
	// address walk
	// ****************************************************************
	logic [ADDR_W-1:0] addr_q;
	logic [ADDR_W-1:0] addr_next;

	flrlw_wrap_addr #(
		.ADDR_W(ADDR_W)
	) u_wrap (
		.cur_addr(addr_q),
		.wrap_en(WRAP_ENABLE_BIT),
		.burst_len({BURST_SIZE_BIT_HIGH, BURST_SIZE_BIT_LOW}),
		.next_addr(addr_next)
	);

	// address loads at end of address phase, steps per delivered byte
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			addr_q <= '0;
		end else if (state_q == FLRLW_ADDR && ADDR_DONE) begin
			addr_q <= START_ADDR;
		end else if (state_q == FLRLW_DATA && BYTE_DONE) begin
			addr_q <= addr_next;
		end
	end

	// ****************************************************************
	// registered outputs
	// ****************************************************************
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			DATA_ENABLE <= 1'b0;
			IN_DUMMY <= 1'b0;
			CMD_REJECT <= 1'b0;
			LATENCY <= `FLRLW_LAT_FAST_SERIAL;
			READ_ADDR <= '0;
		end else begin
			DATA_ENABLE <= (state_d == FLRLW_DATA);
			IN_DUMMY <= (state_d == FLRLW_DUMMY);
			CMD_REJECT <= CMD_VALID & (~cmd_known | cmd_bad_mode);
			LATENCY <= lat_q;
			READ_ADDR <= addr_q;
		end
	end

endmodule // flrlw_read_latency

// ===== hw/flrlw_wrap_addr.sv
`timescale 1ns/10ps
`include "flrlw_consts.svh"

// next byte address of a continuous read, linear or wrapped
module flrlw_wrap_addr #(
	parameter int ADDR_W = `FLRLW_ADDR_W
) (
	input wire logic [ADDR_W-1:0] cur_addr,
	input wire logic wrap_en,
	input wire flrlw_pkg::flrlw_burst_t burst_len,
	output logic [ADDR_W-1:0] next_addr
);
	import flrlw_pkg::*;

	logic [6:0] span;
	logic [ADDR_W-1:0] mask;
	logic [ADDR_W-1:0] inc;

	// boundary size and low-bit mask
	always_comb begin
		unique case (burst_len)
			2'b00: span = `FLRLW_WRAP_8;
			2'b01: span = `FLRLW_WRAP_16;
			2'b10: span = `FLRLW_WRAP_32;
			2'b11: span = `FLRLW_WRAP_64;
		endcase
		mask = ADDR_W'(span) - ADDR_W'(1);
		inc = cur_addr + ADDR_W'(1);
	end

	// wrapping keeps the upper bits, only the low offset rolls
	always_comb begin
		if (wrap_en) begin
			next_addr = (cur_addr & ~mask) | (inc & mask);
		end else begin
			next_addr = inc;
		end
	end

endmodule // flrlw_wrap_addr

// ===== verification/flrlw_assertions.sv
`timescale 1ns/10ps
// ****
// read phase checks
// ****
module flrlw_chk #(
	parameter int ADDR_W = 24
) (
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire logic CS_N,
	input wire logic CMD_VALID,
	input wire logic ADDR_DONE,
	input wire logic WRAP_ENABLE_BIT,
	input wire logic BURST_SIZE_BIT_HIGH,
	input wire logic BURST_SIZE_BIT_LOW,
	input wire flrlw_pkg::flrlw_lat_t DUMMY_CYCLES,
	input wire logic DATA_ENABLE,
	input wire logic IN_DUMMY,
	input wire logic CMD_REJECT,
	input wire flrlw_pkg::flrlw_lat_t LATENCY,
	input wire logic [ADDR_W-1:0] READ_ADDR
);
	import flrlw_pkg::*;
	logic [ADDR_W-1:0] msk;
	// low address bits that roll inside the wrap block
	assign msk = (ADDR_W'(8) << {BURST_SIZE_BIT_HIGH, BURST_SIZE_BIT_LOW}) - ADDR_W'(1);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (RST);
	// one address step inside the data phase
	sequence s_step;
		DATA_ENABLE && $past(DATA_ENABLE) && $changed(READ_ADDR);
	endsequence
	a_reset_vals: assert property (disable iff (1'b0) RST |=> !DATA_ENABLE && !IN_DUMMY && !CMD_REJECT
		&& LATENCY == 4'h8 && READ_ADDR == '0) else $error("reset values wrong");
	a_wrap_off: assert property (s_step ##0 !WRAP_ENABLE_BIT |-> READ_ADDR == $past(READ_ADDR) + ADDR_W'(1))
		else $error("linear step wrong");
	a_wrap_on: assert property (s_step ##0 WRAP_ENABLE_BIT |->
		(READ_ADDR & ~msk) == ($past(READ_ADDR) & ~msk)
		&& (READ_ADDR & msk) == (($past(READ_ADDR) + ADDR_W'(1)) & msk)) else $error("wrap step wrong");
	a_lat_exact: assert property (CMD_VALID && DUMMY_CYCLES != 4'h0 && !IN_DUMMY && !DATA_ENABLE
		##1 !CMD_REJECT |-> ##[1:2] LATENCY == DUMMY_CYCLES) else $error("latency not exact");
	a_reject_cause: assert property (CMD_REJECT |-> $past(CMD_VALID)) else $error("reject without command");
	a_reject_pulse: assert property (CMD_REJECT |=> !CMD_REJECT) else $error("reject too long");
	a_phase_excl: assert property (!(IN_DUMMY && DATA_ENABLE)) else $error("dummy and data overlap");
	a_dummy_cause: assert property ($rose(IN_DUMMY) |-> $past(ADDR_DONE)) else $error("dummy without address");
	a_data_cause: assert property ($rose(DATA_ENABLE) |-> $past(IN_DUMMY) && !CS_N)
		else $error("data without dummy phase");
endmodule // flrlw_chk

bind flrlw_read_latency flrlw_chk #(.ADDR_W(ADDR_W)) flrlw_chk_inst (.CORE_CLK(CORE_CLK), .RST(RST), .CS_N(CS_N),
	.CMD_VALID(CMD_VALID), .ADDR_DONE(ADDR_DONE), .WRAP_ENABLE_BIT(WRAP_ENABLE_BIT),
	.BURST_SIZE_BIT_HIGH(BURST_SIZE_BIT_HIGH), .BURST_SIZE_BIT_LOW(BURST_SIZE_BIT_LOW),
	.DUMMY_CYCLES(DUMMY_CYCLES), .DATA_ENABLE(DATA_ENABLE), .IN_DUMMY(IN_DUMMY), .CMD_REJECT(CMD_REJECT),
	.LATENCY(LATENCY), .READ_ADDR(READ_ADDR));

// ===== verification/flrlw_host_model.sv
`timescale 1ns/10ps
// ****
// host serial clock
// ****
module flrlw_host_model (
	input wire logic run,
	output logic sclk
);
	// slow clock, 320 ns period is well under every limit
	// drives no data lines, so the latency phase sees no contention
	// clock stands low between frames, a period already begun is finished
	initial begin
		sclk = 1'b0;
		forever begin
			wait (run);
			#160 sclk = 1'b1;
			#160 sclk = 1'b0;
		end
	end
endmodule // flrlw_host_model

// ===== verification/tb_top.sv
`timescale 1ns/10ps
// ****
// read latency and wrap bench
// ****
module tb_top;
	import flrlw_pkg::*;
	logic clk = 0, rst = 1, cs_n = 1, cv = 0, fw = 0, ad = 0, bd = 0, we = 0, bh = 0, bl = 0, run = 0, rs;
	logic de, ind, rej, sclk;
	logic [7:0] code = 8'h0;
	logic [23:0] sa = 24'h0, ra;
	flrlw_lat_t dc = 4'h0, lat;
	int n_fail = 0, n_tests = 0, nf = 0;
	logic [7:0] tc [13] = '{8'h0b, 8'h0d, 8'h0b, 8'h0d, 8'h3b, 8'h6b, 8'hbb, 8'hbd, 8'heb, 8'hed, 8'heb, 8'hf1, 8'hf2};
	logic tf [13] = '{0, 0, 1, 1, 0, 0, 0, 0, 0, 0, 1, 0, 0};
	flrlw_lat_t te [13] = '{8, 8, 6, 6, 8, 8, 4, 4, 6, 6, 6, 8, 8};
	logic [7:0] rc [5] = '{8'h3b, 8'h6b, 8'hbb, 8'hbd, 8'h00};
	initial forever #20 clk = ~clk;
	flrlw_read_latency flrlw_read_latency_inst (.CORE_CLK(clk), .RST(rst), .SCLK(sclk), .CS_N(cs_n),
		.CMD_VALID(cv), .CMD_CODE(code), .FOUR_WIRE_MODE(fw), .ADDR_DONE(ad), .START_ADDR(sa), .BYTE_DONE(bd),
		.WRAP_ENABLE_BIT(we), .BURST_SIZE_BIT_HIGH(bh), .BURST_SIZE_BIT_LOW(bl), .DUMMY_CYCLES(dc),
		.DATA_ENABLE(de), .IN_DUMMY(ind), .CMD_REJECT(rej), .LATENCY(lat), .READ_ADDR(ra));
	flrlw_host_model flrlw_host_model_inst (.run(run), .sclk(sclk));
	// falls are counted, a rise would race the data enable
	always @(negedge sclk) nf = nf + 1;
	task cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task chk(input logic ok, input string m);
		n_tests++;
		if (ok !== 1'b1) begin
			n_fail++;
			$display("mismatch at %0t: %s", $time, m);
		end
	endtask
	// one whole read frame, expected address worked out here
	task frame(input logic [7:0] c, input logic f, input flrlw_lat_t d, input flrlw_lat_t e,
		input logic [23:0] a, input int nb);
		logic [23:0] x, m;
		int k;
		m = (24'h8 << {bh, bl}) - 24'h1;
		x = a;
		fw = f;
		dc = d;
		code = c;
		cs_n = 0;
		cyc(4);
		cv = 1;
		cyc(1);
		cv = 0;
		chk(rej === 1'b0, "legal read refused");
		cyc(3);
		chk(lat === e, "latency");
		sa = a;
		ad = 1;
		cyc(1);
		ad = 0;
		chk(ind === 1'b1 && de === 1'b0, "no dummy phase");
		nf = 0;
		run = 1;
		k = 0;
		while (de !== 1'b1 && k < 400) begin
			cyc(1);
			k++;
		end
		run = 0;
		chk(nf == int'(e), "dummy clocks");
		chk(ra === a, "start address");
		repeat (nb) begin
			bd = 1;
			cyc(1);
			bd = 0;
			cyc(3);
			x = we ? ((x & ~m) | ((x + 24'h1) & m)) : x + 24'h1;
			chk(ra === x, "address step");
		end
		cs_n = 1;
		cyc(6);
		chk(de === 1'b0 && ind === 1'b0, "frame not ended");
	endtask
	task t_defaults;
		foreach (tc[i]) frame(tc[i], tf[i], 4'h0, te[i], 24'h100, 1);
	endtask
	task t_exact;
		frame(8'h0b, 0, 4'h1, 4'h1, 24'h20, 1);
		frame(8'heb, 1, 4'hf, 4'hf, 24'h20, 1);
	endtask
	task t_wrap;
		we = 1;
		for (int b = 0; b < 4; b++) begin
			{bh, bl} = 2'(b);
			frame(8'h0b, 0, 4'h0, 4'h8, 24'h12347d, 5);
		end
	endtask
	task t_linear;
		we = 0;
		{bh, bl} = 2'h3;
		frame(8'hbb, 0, 4'h0, 4'h4, 24'hfffffe, 3);
	endtask
	// host side: these opcodes are sent in four-wire mode only to be refused
	task t_reject;
		foreach (rc[i]) begin
			fw = 1;
			cs_n = 0;
			cyc(4);
			code = rc[i];
			cv = 1;
			cyc(1);
			cv = 0;
			rs = 0;
			repeat (3) begin
				rs = rs | rej;
				cyc(1);
			end
			chk(rs === 1'b1, "no refusal");
			ad = 1;
			cyc(1);
			ad = 0;
			cyc(2);
			chk(ind === 1'b0, "refused read went on");
			cs_n = 1;
			cyc(6);
		end
	endtask
	task finish_test;
		$display("tests %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// bench always sets enough dummies for its reads
	initial begin
		cyc(12);
		rst = 0;
		cyc(4);
		t_defaults;
		t_exact;
		t_wrap;
		t_linear;
		t_reject;
		finish_test;
	end
	// watchdog, about six times the expected run
	initial begin
		#400000;
		n_fail++;
		finish_test;
	end
endmodule // tb_top
